/* File: rtl/dpcs_pkg.sv */
package dpcs_pkg;
  // ****************************************************************
  // settings encodings
  // ****************************************************************
  localparam logic [1:0] LOCK_ZERO = 2'h1;
  localparam logic [1:0] LOCK_LAST = 2'h2;
  localparam logic [1:0] LOCK_RESET = 2'h2;
  localparam logic [1:0] AWU_OFF = 2'h0;
  localparam logic [1:0] AWU_LIMIT = 2'h1;
  localparam logic [1:0] AWU_INPUT = 2'h2;
  localparam logic [1:0] AWU_EITHER = 2'h3;
  localparam logic [1:0] AWU_RESET = 2'h1;
  localparam logic [1:0] HEAT_OFF = 2'h0;
  localparam logic [1:0] HEAT_ACTIVE = 2'h1;
  localparam logic [1:0] HEAT_INPUT = 2'h2;
  localparam logic [1:0] MSW_OFF = 2'h0;
  localparam logic [1:0] MSW_DRIVE = 2'h1;
  localparam logic [15:0] MULT_RESET = 16'h0001;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  localparam logic [15:0] OFFS_RESET = 16'h0000;
  localparam logic [5:0] UNIT_RESET = 6'h00;
  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MULT = 8'h04;
  localparam logic [7:0] A_DIV = 8'h08;
  localparam logic [7:0] A_OFFS = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_PIDO = 8'h14;
  localparam logic [7:0] A_DREF = 8'h18;
  localparam logic [7:0] A_DACT = 8'h1C;
  localparam logic [7:0] A_DDEV = 8'h20;
  // ctrl fields
  localparam int C_LOCK = 0;
  localparam int C_AWU = 2;
  localparam int C_HEAT = 4;
  localparam int C_MSW = 6;
  localparam int C_LCE = 8;
  localparam int C_FRST = 9;
  localparam int C_UNIT = 16;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ = 200000000;
  localparam longint LINE_TO_MS = 3000;
  localparam longint MOTOR_TO_MS = 1000;
  localparam longint LINE_TO_CYC = LINE_TO_MS * CLK_HZ / 1000;
  localparam longint MOTOR_TO_CYC = MOTOR_TO_MS * CLK_HZ / 1000;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_DECEL = 2'b10
  } dpcs_run_t;

  typedef struct packed {
    logic [1:0] lock_sel;
    logic [1:0] awu_sel;
    logic [1:0] heat_sel;
    logic [1:0] msw_sel;
    logic line_en;
    logic [5:0] unit;
    logic [15:0] mult;
    logic [15:0] div;
    logic [15:0] offs;
  } dpcs_cfg_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic fault;
    logic lock_sig;
    logic decel_done;
    logic dc_ok;
    logic aux_closed;
    logic aux_used;
    logic heat_dig_in;
    logic awu_dig_in;
    logic drive_limit;
    logic loop_locked;
    logic eco_active;
  } dpcs_plant_t;
endpackage : dpcs_pkg

/* File: rtl/dpcs_top.sv */
`timescale 1ns/1ps
// Contract
// - zero lock halts algorithm, output zero
// - last-value lock holds output at lock
// - anti-wind-up off: integrator runs to limit
// - limitation mode freezes integrator on limit
// - input mode lets digital input stop integrator
// - combined mode stops on limit or input
// - display value times mult, div, plus offset
// - read-only energy-saving state indication
// - heating active mode heats in stop state
// - start command ends winding heating
// - input-dependent heating follows configured input
// - start command closes line contactor output
// - stop opens line contactor after deceleration
// - fault or lock opens line contactor now
// - no DC link in 3 s: fault
// - drive mode: motor contactor follows start/decel
// - auxiliary contact supervises motor contactor
// - contactor state miss in 1 s: fault
module dpcs_top #(
  parameter longint LINE_TO = dpcs_pkg::LINE_TO_CYC,
  parameter longint MOTOR_TO = dpcs_pkg::MOTOR_TO_CYC,
  parameter int IW = 24
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // plant and controller side
  input wire dpcs_pkg::dpcs_plant_t plant,
  input wire logic signed [15:0] alg_out,
  input wire logic signed [15:0] alg_delta,
  input wire logic signed [15:0] pid_ref,
  input wire logic signed [15:0] pid_act,
  // outputs
  output logic signed [15:0] pid_out,
  output logic integ_hold,
  output logic alg_halt,
  output logic heating_on,
  output logic line_contactor,
  output logic motor_contactor,
  output logic line_fault,
  output logic motor_fault
);
  // timers are 32 bits wide, the integrator needs headroom above 16 bits
  if (LINE_TO < 2 || MOTOR_TO < 2 || IW < 17 ||
      LINE_TO > 64'h100000000 || MOTOR_TO > 64'h100000000) begin : g_bad
    $error("dpcs_top: bad parameters");
  end

  typedef struct packed {
    dpcs_pkg::dpcs_cfg_t cfg;
    dpcs_pkg::dpcs_run_t run;
    logic acc_pend;
    logic acc_wr;
    logic [7:0] acc_addr;
    logic [31:0] rdata;
    logic signed [IW-1:0] integ;
    logic signed [15:0] out;
    logic hold;
    logic halt;
    logic heat;
    logic heat_req;
    logic line_c;
    logic motor_c;
    logic [31:0] line_cnt;
    logic [31:0] motor_cnt;
    logic line_f;
    logic motor_f;
    logic signed [15:0] d_ref;
    logic signed [15:0] d_act;
    logic signed [15:0] d_dev;
  } dpcs_state_t;

  dpcs_state_t s;
  dpcs_state_t next_s;

  // ****************************************************************
  // display scaling
  // ****************************************************************
  function automatic logic signed [15:0] scale(
      input logic signed [15:0] v, input dpcs_pkg::dpcs_cfg_t c);
    logic signed [31:0] p;
    logic signed [31:0] q;
    p = 32'(v) * 32'($signed(c.mult));
    q = p / 32'($signed({1'b0, c.div[14:0]}));
    scale = 16'(q + 32'($signed(c.offs)));
  endfunction : scale

  logic awu_stop;
  logic fault_any;
  logic signed [IW-1:0] integ_sum;
  logic signed [IW-1:0] ilim;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  always_comb begin
    ilim = {2'b00, {(IW-2){1'b1}}};
    integ_sum = s.integ + IW'(alg_delta);
    fault_any = s.line_f | s.motor_f;
    ctrl_rd = '0;
    ctrl_rd[dpcs_pkg::C_LOCK +: 2] = s.cfg.lock_sel;
    ctrl_rd[dpcs_pkg::C_AWU +: 2] = s.cfg.awu_sel;
    ctrl_rd[dpcs_pkg::C_HEAT +: 2] = s.cfg.heat_sel;
    ctrl_rd[dpcs_pkg::C_MSW +: 2] = s.cfg.msw_sel;
    ctrl_rd[dpcs_pkg::C_LCE] = s.cfg.line_en;
    ctrl_rd[dpcs_pkg::C_UNIT +: 6] = s.cfg.unit;
    stat_rd = {24'h000000, s.run, plant.eco_active, s.heat,
      s.motor_c, s.line_c, s.motor_f, s.line_f};
    case (s.cfg.awu_sel)
      dpcs_pkg::AWU_OFF: awu_stop = 1'b0;
      dpcs_pkg::AWU_LIMIT: awu_stop = plant.drive_limit;
      dpcs_pkg::AWU_INPUT: awu_stop = plant.awu_dig_in;
      default: awu_stop = plant.drive_limit | plant.awu_dig_in;
    endcase
  end

  always_comb begin
    next_s = s;
    // ****************************************************************
    // bus slave: zero wait states, unmapped reads zero
    // ****************************************************************
    if (s.acc_pend && s.acc_wr) begin
      if (s.acc_addr == dpcs_pkg::A_CTRL) begin
        next_s.cfg.lock_sel = hwdata[dpcs_pkg::C_LOCK +: 2];
        next_s.cfg.awu_sel = hwdata[dpcs_pkg::C_AWU +: 2];
        next_s.cfg.heat_sel = hwdata[dpcs_pkg::C_HEAT +: 2];
        next_s.cfg.msw_sel = hwdata[dpcs_pkg::C_MSW +: 2];
        next_s.cfg.line_en = hwdata[dpcs_pkg::C_LCE];
        next_s.cfg.unit = hwdata[dpcs_pkg::C_UNIT +: 6];
      end else if (s.acc_addr == dpcs_pkg::A_MULT) begin
        next_s.cfg.mult = hwdata[15:0];
      end else if (s.acc_addr == dpcs_pkg::A_DIV) begin
        // divisor kept positive so the scaler never divides by zero
        next_s.cfg.div = (hwdata[14:0] == 15'h0000) ?
          16'h0001 : {1'b0, hwdata[14:0]};
      end else if (s.acc_addr == dpcs_pkg::A_OFFS) begin
        next_s.cfg.offs = hwdata[15:0];
      end
    end
    next_s.acc_pend = hsel & hready & htrans[1];
    next_s.acc_wr = hwrite;
    next_s.acc_addr = haddr[7:0];
    next_s.rdata = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr[7:0] == dpcs_pkg::A_CTRL) begin
        next_s.rdata = ctrl_rd;
      end else if (haddr[7:0] == dpcs_pkg::A_MULT) begin
        next_s.rdata = {16'h0000, s.cfg.mult};
      end else if (haddr[7:0] == dpcs_pkg::A_DIV) begin
        next_s.rdata = {16'h0000, s.cfg.div};
      end else if (haddr[7:0] == dpcs_pkg::A_OFFS) begin
        next_s.rdata = {16'h0000, s.cfg.offs};
      end else if (haddr[7:0] == dpcs_pkg::A_STAT) begin
        next_s.rdata = stat_rd;
      end else if (haddr[7:0] == dpcs_pkg::A_PIDO) begin
        next_s.rdata = {16'h0000, s.out};
      end else if (haddr[7:0] == dpcs_pkg::A_DREF) begin
        next_s.rdata = {16'h0000, s.d_ref};
      end else if (haddr[7:0] == dpcs_pkg::A_DACT) begin
        next_s.rdata = {16'h0000, s.d_act};
      end else if (haddr[7:0] == dpcs_pkg::A_DDEV) begin
        next_s.rdata = {16'h0000, s.d_dev};
      end
    end

    // ****************************************************************
    // controller output, lock and anti-wind-up
    // ****************************************************************
    next_s.halt = plant.loop_locked;
    next_s.hold = plant.loop_locked | awu_stop;
    if (plant.loop_locked) begin
      if (s.cfg.lock_sel == dpcs_pkg::LOCK_ZERO) begin
        next_s.out = 16'sh0000;
      end else begin
        next_s.out = s.out;
      end
    end else begin
      next_s.out = alg_out;
      if (!awu_stop) begin
        // saturating integrator models the internal limit
        if (integ_sum > ilim) begin
          next_s.integ = ilim;
        end else if (integ_sum < -ilim) begin
          next_s.integ = -ilim;
        end else begin
          next_s.integ = integ_sum;
        end
      end
    end
    next_s.d_ref = scale(pid_ref, s.cfg);
    next_s.d_act = scale(pid_act, s.cfg);
    next_s.d_dev = scale(16'(pid_ref - pid_act), s.cfg);

    // ****************************************************************
    // run sequence and contactors
    // ****************************************************************
    case (s.run)
      dpcs_pkg::ST_STOP: begin
        if (plant.start && !fault_any) begin
          next_s.run = dpcs_pkg::ST_RUN;
        end
      end
      dpcs_pkg::ST_RUN: begin
        if (plant.fault || plant.lock_sig) begin
          next_s.run = dpcs_pkg::ST_STOP;
        end else if (plant.stop) begin
          next_s.run = dpcs_pkg::ST_DECEL;
        end
      end
      dpcs_pkg::ST_DECEL: begin
        if (plant.fault || plant.lock_sig || plant.decel_done) begin
          next_s.run = dpcs_pkg::ST_STOP;
        end else if (plant.start) begin
          next_s.run = dpcs_pkg::ST_RUN;
        end
      end
      default: next_s.run = dpcs_pkg::ST_STOP;
    endcase
    if (fault_any) begin
      next_s.run = dpcs_pkg::ST_STOP;
    end
    // fault and lock cut the line contactor the same cycle
    next_s.line_c = s.cfg.line_en && (next_s.run != dpcs_pkg::ST_STOP)
      && !plant.fault && !plant.lock_sig && !fault_any;
    next_s.motor_c = (s.cfg.msw_sel == dpcs_pkg::MSW_DRIVE) && !fault_any
      && (next_s.run != dpcs_pkg::ST_STOP);

    // heating only while idle; a start command drops it at once
    next_s.heat_req = (s.cfg.heat_sel == dpcs_pkg::HEAT_ACTIVE) ||
      ((s.cfg.heat_sel == dpcs_pkg::HEAT_INPUT) && plant.heat_dig_in);
    next_s.heat = s.heat_req && !plant.start && !fault_any
      && (s.run == dpcs_pkg::ST_STOP);

    // fault reset first, so a timeout in the same cycle still sets
    if (s.acc_pend && s.acc_wr && s.acc_addr == dpcs_pkg::A_CTRL
        && hwdata[dpcs_pkg::C_FRST]) begin
      next_s.line_f = 1'b0;
      next_s.motor_f = 1'b0;
    end
    // supervision timers
    if (s.line_c && !plant.dc_ok) begin
      if (s.line_cnt >= 32'(LINE_TO - 1)) begin
        next_s.line_f = 1'b1;
      end else begin
        next_s.line_cnt = s.line_cnt + 32'h00000001;
      end
    end else begin
      next_s.line_cnt = '0;
    end
    if (plant.aux_used && (s.motor_c != plant.aux_closed)) begin
      if (s.motor_cnt >= 32'(MOTOR_TO - 1)) begin
        next_s.motor_f = 1'b1;
      end else begin
        next_s.motor_cnt = s.motor_cnt + 32'h00000001;
      end
    end else begin
      next_s.motor_cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cfg.lock_sel <= dpcs_pkg::LOCK_RESET;
      s.cfg.awu_sel <= dpcs_pkg::AWU_RESET;
      s.cfg.mult <= dpcs_pkg::MULT_RESET;
      s.cfg.div <= dpcs_pkg::DIV_RESET;
      s.cfg.offs <= dpcs_pkg::OFFS_RESET;
      s.cfg.unit <= dpcs_pkg::UNIT_RESET;
      s.run <= dpcs_pkg::ST_STOP;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pid_out = s.out;
  assign integ_hold = s.hold;
  assign alg_halt = s.halt;
  assign heating_on = s.heat;
  assign line_contactor = s.line_c;
  assign motor_contactor = s.motor_c;
  assign line_fault = s.line_f;
  assign motor_fault = s.motor_f;
endmodule : dpcs_top

/* File: verif/dpcs_plant_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// contactors, auxiliary contact and dc link
// ****************************************************************
module dpcs_plant_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // coils driven by the drive
  input wire logic line_contactor,
  input wire logic motor_contactor,
  // fault injection from the bench
  input wire logic dc_dead,
  input wire logic aux_stuck,
  // feedback to the drive
  output logic dc_ok,
  output logic aux_closed
);
  logic [3:0] lsh;
  logic [2:0] msh;
  // dc link charges a few cycles after mains closes, drops at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsh <= 4'h0;
      msh <= 3'h0;
    end else begin
      lsh <= line_contactor ? {lsh[2:0], 1'b1} : 4'h0;
      // a welded or broken contact holds its last position
      if (!aux_stuck) msh <= {msh[1:0], motor_contactor};
    end
  end
  assign dc_ok = lsh[3] & !dc_dead;
  assign aux_closed = msh[2];
endmodule : dpcs_plant_model

/* File: verif/dpcs_top_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module dpcs_top_assertions #(
  parameter longint LINE_TO = 20,
  parameter longint MOTOR_TO = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // plant and outputs
  input wire dpcs_pkg::dpcs_plant_t plant,
  input wire logic integ_hold,
  input wire logic alg_halt,
  input wire logic heating_on,
  input wire logic line_contactor,
  input wire logic motor_contactor,
  input wire logic line_fault,
  input wire logic motor_fault
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);
  longint lc_cnt;
  longint mc_cnt;
  // waits counted beside the design, so early faults show up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lc_cnt <= 0;
      mc_cnt <= 0;
    end else begin
      lc_cnt <= (line_contactor && !plant.dc_ok) ? lc_cnt + 1 : 0;
      mc_cnt <= (plant.aux_used && plant.aux_closed != motor_contactor) ?
                mc_cnt + 1 : 0;
    end
  end
  fault_drop_a: assert property (plant.fault |=> !line_contactor)
    else $error("line contactor held after fault");
  lock_drop_a: assert property (plant.lock_sig |=> !line_contactor)
    else $error("line contactor held after lock");
  latch_off_a: assert property ((line_fault || motor_fault) &&
    $past(line_fault || motor_fault) |-> !line_contactor && !motor_contactor)
    else $error("contactor on while fault latched");
  line_wait_a: assert property ($rose(line_fault) |->
    lc_cnt + 2 >= LINE_TO) else $error("line fault too early");
  motor_wait_a: assert property ($rose(motor_fault) |->
    $past(plant.aux_used) && mc_cnt + 2 >= MOTOR_TO)
    else $error("motor fault too early");
  lock_halt_a: assert property (plant.loop_locked |=>
    alg_halt && integ_hold) else $error("locked loop not halted");
  start_heat_a: assert property (plant.start |-> ##2 !heating_on)
    else $error("heating kept after start");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  cover property ($rose(line_fault));
  cover property ($rose(motor_fault));
  cover property (plant.loop_locked ##1 alg_halt);
  cover property (line_contactor && plant.dc_ok && motor_contactor);
endmodule : dpcs_top_assertions

bind dpcs_top dpcs_top_assertions #(.LINE_TO(LINE_TO), .MOTOR_TO(MOTOR_TO))
  u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hreadyout(hreadyout), .hresp(hresp), .plant(plant),
  .integ_hold(integ_hold), .alg_halt(alg_halt), .heating_on(heating_on),
  .line_contactor(line_contactor), .motor_contactor(motor_contactor),
  .line_fault(line_fault), .motor_fault(motor_fault));

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [31:0] m; logic [31:0] e;} dpcs_note_t;
  localparam longint LTO = 20;
  localparam longint MTO = 10;
  localparam int P_START = 12;
  localparam int P_STOP = 11;
  localparam int P_DDONE = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] ctrl;
  logic hro, hresp, integ_hold, alg_halt, heating_on, lc, mc, lf, mf;
  logic dc_ok, aux, e1;
  logic dc_dead = 1'b0;
  logic stuck = 1'b0;
  logic rd_ph = 1'b0;
  logic obs_p = 1'b0;
  logic [15:0] rnd = 16'h2A49;
  logic signed [15:0] alg_out = 16'h0;
  logic signed [15:0] alg_delta = 16'h0;
  logic signed [15:0] pid_ref = 16'h0;
  logic signed [15:0] pid_act = 16'h0;
  logic signed [15:0] pid_out;
  dpcs_pkg::dpcs_plant_t pl = '0;
  dpcs_pkg::dpcs_plant_t pin;
  dpcs_note_t q[$];
  int n_fail = 0;
  int tests_run = 0;
  int i, mul, dv, of, v;
  wire logic [6:0] outv = {mf, lf, mc, lc, heating_on, alg_halt, integ_hold};
  initial forever #2.5 hclk = ~hclk;
  always_comb begin
    pin = pl;
    pin.dc_ok = dc_ok;
    pin.aux_closed = aux;
  end
  dpcs_top #(.LINE_TO(LTO), .MOTOR_TO(MTO)) dut (.hclk(hclk),
    .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hro), .hrdata(hrdata), .hreadyout(hro), .hresp(hresp),
    .plant(pin), .alg_out(alg_out), .alg_delta(alg_delta),
    .pid_ref(pid_ref), .pid_act(pid_act), .pid_out(pid_out),
    .integ_hold(integ_hold), .alg_halt(alg_halt), .heating_on(heating_on),
    .line_contactor(lc), .motor_contactor(mc), .line_fault(lf),
    .motor_fault(mf));
  dpcs_plant_model partner (.hclk(hclk), .hresetn(hresetn),
    .line_contactor(lc), .motor_contactor(mc), .dc_dead(dc_dead),
    .aux_stuck(stuck), .dc_ok(dc_ok), .aux_closed(aux));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input string nm, input logic [31:0] e, m, g);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic wait_out(input int b, input longint n);
    longint k;
    for (k = 0; k < n && outv[b] !== 1'b1; k++) @(posedge hclk);
    if (outv[b] !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end
  endtask : wait_out
  // holds the current phase until hready is sampled high at an edge
  task automatic step;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hro !== 1'b1 && k < 50);
    if (hro !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end
  endtask : step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, m);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    step;
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (w) hwdata <= d;
    else q.push_back({m, d});
    rd_ph <= !w;
    step;
    rd_ph <= 1'b0;
  endtask : xfer
  task automatic cfg(input logic [1:0] lk, aw, ht, ms, input logic le);
    ctrl = {23'h0, le, ms, ht, aw, lk};
    xfer(1'b1, dpcs_pkg::A_CTRL, ctrl, 32'h0);
    cyc(2);
  endtask : cfg
  task automatic obs(input logic [6:0] m, e);
    q.push_back({25'h0, m, 25'h0, e});
    obs_p <= 1'b1;
    @(posedge hclk);
    obs_p <= 1'b0;
    @(posedge hclk);
  endtask : obs
  task automatic pulse(input int b);
    pl[b] <= 1'b1;
    cyc(1);
    pl[b] <= 1'b0;
    cyc(8);
  endtask : pulse
  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(posedge hclk) begin
    if (rd_ph && hro === 1'b1) cmp("hrdata", q[0].e, q[0].m, hrdata);
    if (obs_p) cmp("outputs", q[0].e, q[0].m, {25'h0, outv});
    if (rd_ph || obs_p) void'(q.pop_front());
  end
  initial begin
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    xfer(0, dpcs_pkg::A_CTRL, {10'h0, dpcs_pkg::UNIT_RESET, 12'h0,
      dpcs_pkg::AWU_RESET, dpcs_pkg::LOCK_RESET}, 32'h003F01FF);
    xfer(0, dpcs_pkg::A_MULT, 32'(dpcs_pkg::MULT_RESET), 32'hFFFF);
    xfer(0, 8'h40, 32'h0, 32'hFFFFFFFF);
    xfer(1, dpcs_pkg::A_DIV, 32'h0, 32'h0);
    xfer(0, dpcs_pkg::A_DIV, 32'h1, 32'hFFFF);
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      mul = int'(rnd % 2001) - 1000;
      xfer(1, dpcs_pkg::A_MULT, 32'(mul), 32'h0);
      rnd = lfsr(rnd);
      dv = int'(rnd % 1000) + 1;
      xfer(1, dpcs_pkg::A_DIV, 32'(dv), 32'h0);
      rnd = lfsr(rnd);
      of = int'(rnd % 201) - 100;
      xfer(1, dpcs_pkg::A_OFFS, 32'(of), 32'h0);
      rnd = lfsr(rnd);
      v = int'(rnd % 61) - 30;
      pid_ref <= 16'(v);
      pid_act <= 16'(-v);
      alg_delta <= rnd;
      pl.eco_active <= rnd[0];
      cyc(3);
      xfer(0, dpcs_pkg::A_DREF, 32'(v * mul / dv + of), 32'hFFFF);
      xfer(0, dpcs_pkg::A_DACT, 32'(-v * mul / dv + of), 32'hFFFF);
      xfer(0, dpcs_pkg::A_DDEV, 32'(2 * v * mul / dv + of), 32'hFFFF);
      xfer(0, dpcs_pkg::A_STAT, {26'h0, rnd[0], 5'h0}, 32'h20);
      xfer(1, dpcs_pkg::A_CTRL, {10'h0, rnd[5:0], 16'h0006}, 32'h0);
      xfer(0, dpcs_pkg::A_CTRL, {10'h0, rnd[5:0], 16'h0006},
        32'h003F03FF);
    end
    alg_out <= 16'h04D2;
    cfg(dpcs_pkg::LOCK_ZERO, dpcs_pkg::AWU_OFF, 2'h0, 2'h0, 1'b0);
    xfer(0, dpcs_pkg::A_PIDO, 32'h04D2, 32'hFFFF);
    pl.loop_locked <= 1'b1;
    cyc(3);
    xfer(0, dpcs_pkg::A_PIDO, 32'h0, 32'hFFFF);
    pl.loop_locked <= 1'b0;
    cfg(dpcs_pkg::LOCK_LAST, dpcs_pkg::AWU_OFF, 2'h0, 2'h0, 1'b0);
    pl.loop_locked <= 1'b1;
    cyc(2);
    alg_out <= 16'h022B;
    cyc(2);
    xfer(0, dpcs_pkg::A_PIDO, 32'h04D2, 32'hFFFF);
    pl.loop_locked <= 1'b0;
    cyc(2);
    xfer(0, dpcs_pkg::A_PIDO, 32'h022B, 32'hFFFF);
    for (i = 0; i < 16; i++) begin
      cfg(dpcs_pkg::LOCK_LAST, i[3:2], 2'h0, 2'h0, 1'b0);
      pl.drive_limit <= i[0];
      pl.awu_dig_in <= i[1];
      e1 = (i[3:2] == dpcs_pkg::AWU_LIMIT && i[0]) ||
           (i[3:2] == dpcs_pkg::AWU_INPUT && i[1]) ||
           (i[3:2] == dpcs_pkg::AWU_EITHER && (i[0] || i[1]));
      cyc(2);
      obs(7'h01, {6'h0, e1});
    end
    pl.drive_limit <= 1'b0;
    pl.awu_dig_in <= 1'b0;
    cfg(dpcs_pkg::LOCK_LAST, 2'h0, dpcs_pkg::HEAT_ACTIVE, 2'h0, 1'b0);
    obs(7'h04, 7'h04);
    pl.heat_dig_in <= 1'b1;
    pl.start <= 1'b1;
    cyc(2);
    obs(7'h04, 7'h00);
    pl.start <= 1'b0;
    pulse(P_STOP);
    pulse(P_DDONE);
    cfg(dpcs_pkg::LOCK_LAST, 2'h0, dpcs_pkg::HEAT_INPUT, 2'h0, 1'b0);
    obs(7'h04, 7'h04);
    pl.heat_dig_in <= 1'b0;
    cyc(2);
    obs(7'h04, 7'h00);
    cfg(dpcs_pkg::LOCK_LAST, 2'h0, 2'h0, dpcs_pkg::MSW_DRIVE, 1'b1);
    pl.aux_used <= 1'b1;
    pulse(P_START);
    obs(7'h18, 7'h18);
    pulse(P_STOP);
    obs(7'h18, 7'h18);
    pulse(P_DDONE);
    obs(7'h18, 7'h00);
    for (i = 9; i < 11; i++) begin
      pulse(P_START);
      pl[i] <= 1'b1;
      cyc(1);
      obs(7'h08, 7'h00);
      pl[i] <= 1'b0;
      pulse(P_STOP);
      pulse(P_DDONE);
    end
    dc_dead <= 1'b1;
    pulse(P_START);
    wait_out(5, LTO + 8);
    obs(7'h38, 7'h20);
    dc_dead <= 1'b0;
    pulse(P_START);
    obs(7'h38, 7'h20);
    xfer(1, dpcs_pkg::A_CTRL, ctrl | 32'h200, 32'h0);
    cyc(2);
    obs(7'h20, 7'h00);
    stuck <= 1'b1;
    pulse(P_START);
    wait_out(6, MTO + 8);
    obs(7'h58, 7'h40);
    stuck <= 1'b0;
    xfer(1, dpcs_pkg::A_CTRL, ctrl | 32'h200, 32'h0);
    cyc(2);
    obs(7'h40, 7'h00);
    pulse(P_START);
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    obs(7'h7F, 7'h00);
    tally_and_finish;
  end
endmodule : tb
